// ---- chgst_pkg.sv ----
/*
 * chgst_pkg: register offsets, field positions and status encodings
 * for the charger status register bank.
 * assumes: an 8-bit register address and 8-bit read data.
 */
package chgst_pkg;

    // register offsets
    localparam logic [7:0] CHGST_ADDR_STATUS_ONE = 8'h0b;
    localparam logic [7:0] CHGST_ADDR_STATUS_TWO = 8'h0c;
    localparam logic [7:0] CHGST_ADDR_THERMISTOR = 8'h0d;
    localparam logic [7:0] CHGST_ADDR_FAULT = 8'h0e;

    // field positions in charge_status_one
    localparam int CHGST_POS_ICUR = 6;
    localparam int CHGST_POS_IVOLT = 5;
    localparam int CHGST_POS_THERM = 4;
    localparam int CHGST_POS_WDOG = 3;
    localparam int CHGST_POS_PHASE = 0;

    // field positions in charge_status_two
    localparam int CHGST_POS_GOOD = 7;
    localparam int CHGST_POS_SOURCE = 4;
    localparam int CHGST_POS_OPT = 1;

    // field positions in fault_status
    localparam int CHGST_POS_OVP = 7;
    localparam int CHGST_POS_SHUT = 6;
    localparam int CHGST_POS_TMR = 4;

    // count of weak-source detections that flags a poor source
    localparam logic [2:0] CHGST_WEAK_LIMIT = 3'h7;

    localparam logic [7:0] CHGST_ZERO = 8'h00;

    // charge phase codes
    typedef enum logic [2:0] {
        CHGST_PH_IDLE = 3'h0,
        CHGST_PH_TRICKLE = 3'h1,
        CHGST_PH_PRE = 3'h2,
        CHGST_PH_CC = 3'h3,
        CHGST_PH_CV = 3'h4,
        CHGST_PH_TOPOFF = 3'h5,
        CHGST_PH_DONE = 3'h6
    } chgst_phase_t;

    // input source codes
    typedef enum logic [2:0] {
        CHGST_SRC_NONE = 3'h0,
        CHGST_SRC_SDP = 3'h1,
        CHGST_SRC_CDP = 3'h2,
        CHGST_SRC_ADAPTER = 3'h3,
        CHGST_SRC_POOR = 3'h4,
        CHGST_SRC_UNKNOWN = 3'h5,
        CHGST_SRC_NONSTD = 3'h6
    } chgst_source_t;

    // current optimizer codes
    typedef enum logic [1:0] {
        CHGST_OPT_OFF = 2'h0,
        CHGST_OPT_BUSY = 2'h1,
        CHGST_OPT_FOUND = 2'h2
    } chgst_opt_t;

    // thermistor zone codes
    localparam logic [2:0] CHGST_TS_NORMAL = 3'h0;
    localparam logic [2:0] CHGST_TS_WARM = 3'h2;
    localparam logic [2:0] CHGST_TS_COOL = 3'h3;
    localparam logic [2:0] CHGST_TS_COLD = 3'h5;
    localparam logic [2:0] CHGST_TS_HOT = 3'h6;

endpackage

// ---- chgst_weak_count.sv ----
/*
 * chgst_weak_count: counts consecutive weak-source detections and
 * raises a level once the limit is reached.
 * assumes: detect pulses are one cycle wide; a good qualification or
 * loss of input clears the run.
 */
`timescale 1ns/100ps
module chgst_weak_count
    import chgst_pkg::*;
#(
    parameter logic [2:0] LIMIT = chgst_pkg::CHGST_WEAK_LIMIT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // detection events
    input wire logic weak_detect,
    input wire logic source_ok,
    input wire logic input_lost,
    // result
    output logic weak_source
);
    import chgst_pkg::*;

    logic [2:0] run;
    logic [2:0] next_run;
    logic next_weak;

    ////////////////////////////////////////////////////////////////////
    // run length, saturating at the limit
    assign next_run = (source_ok || input_lost) ? 3'h0 :
                      (weak_detect && run != LIMIT) ? run + 3'h1 : run;
    assign next_weak = (next_run == LIMIT);

    // state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run <= 3'h0;
            weak_source <= 1'b0;
        end else begin
            run <= next_run;
            weak_source <= next_weak;
        end
    end
endmodule

// ---- chgst_status_regs.sv ----
/*
 * chgst_status_regs: read-only status register bank of a two-cell boost
 * charger, read by the serial control bus front end.
 * assumes: status inputs are synchronous to clock; the bus front end
 * drives rd_addr and samples rd_data one cycle after rd_en.
 */
// Function
// - current loop active reports one
// - voltage loop regulating reports one
// - die thermal regulation reports one
// - watchdog expiry reports one
// - phase codes idle, trickle, pre, fast
// - phase codes taper, topoff, done; seven never
// - source codes none, sdp, cdp, adapter
// - poor source after seven detections
// - source codes unknown and nonstandard
// - optimizer codes off, busy, found; three never
// - reserved bits read zero
`timescale 1ns/100ps
module chgst_status_regs
    import chgst_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // regulation loops and watchdog
    input wire logic input_current_regulation,
    input wire logic current_limit_pin,
    input wire logic input_voltage_regulation,
    input wire logic die_thermal_loop_active,
    input wire logic host_timer_expired,
    // charge cycle
    input wire chgst_pkg::chgst_phase_t charge_phase,
    // input source
    input wire logic supply_good,
    input wire chgst_pkg::chgst_source_t source_detected,
    input wire logic weak_source_detect,
    // current optimizer
    input wire logic input_current_optimizer,
    input wire logic optimizer_found,
    // thermistor zone
    input wire logic [2:0] thermistor_zone,
    // faults
    input wire logic input_overvoltage,
    input wire logic thermal_shutdown,
    input wire logic safety_timer_expired,
    // register read port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    import chgst_pkg::*;

    logic weak_source;
    logic input_current_loop_active;
    logic input_voltage_loop_active;
    logic [2:0] phase_code;
    logic [2:0] input_source_type;
    logic [1:0] current_optimizer_state;
    logic [2:0] zone_code;
    logic [7:0] charge_status_one;
    logic [7:0] charge_status_two;
    logic [7:0] thermistor_status;
    logic [7:0] fault_status;
    logic [7:0] next_rd_data;
    logic hit_one;
    logic hit_two;
    logic hit_ts;
    logic hit_fault;

    ////////////////////////////////////////////////////////////////////
    // poor-source run counter
    chgst_weak_count #(
        .LIMIT(CHGST_WEAK_LIMIT)
    ) u_weak (
        .clock(clock),
        .rst_n(rst_n),
        .weak_detect(weak_source_detect),
        .source_ok(source_detected != CHGST_SRC_NONE && !weak_source_detect),
        .input_lost(!supply_good && source_detected == CHGST_SRC_NONE),
        .weak_source(weak_source)
    );

    ////////////////////////////////////////////////////////////////////
    // regulation loop status
    assign input_current_loop_active = input_current_regulation || current_limit_pin;
    assign input_voltage_loop_active = input_voltage_regulation;

    // charge phase, the reserved code never reaches software
    assign phase_code = (charge_phase == 3'h7) ? CHGST_PH_IDLE : charge_phase;

    // source type, a poor source overrides the detected type
    assign input_source_type = weak_source ? CHGST_SRC_POOR :
                               (source_detected == 3'h7) ? CHGST_SRC_UNKNOWN :
                               source_detected;

    // optimizer state
    assign current_optimizer_state = !input_current_optimizer ? CHGST_OPT_OFF :
                                     optimizer_found ? CHGST_OPT_FOUND : CHGST_OPT_BUSY;

    // thermistor zone, unlisted codes read as normal
    assign zone_code = (thermistor_zone == CHGST_TS_WARM || thermistor_zone == CHGST_TS_COOL ||
                        thermistor_zone == CHGST_TS_COLD || thermistor_zone == CHGST_TS_HOT) ?
                       thermistor_zone : CHGST_TS_NORMAL;

    ////////////////////////////////////////////////////////////////////
    // register images, reserved bits held at zero
    always_comb begin
        charge_status_one = CHGST_ZERO;
        charge_status_one[CHGST_POS_ICUR] = input_current_loop_active;
        charge_status_one[CHGST_POS_IVOLT] = input_voltage_loop_active;
        charge_status_one[CHGST_POS_THERM] = die_thermal_loop_active;
        charge_status_one[CHGST_POS_WDOG] = host_timer_expired;
        charge_status_one[CHGST_POS_PHASE +: 3] = phase_code;
    end

    always_comb begin
        charge_status_two = CHGST_ZERO;
        charge_status_two[CHGST_POS_GOOD] = supply_good;
        charge_status_two[CHGST_POS_SOURCE +: 3] = input_source_type;
        charge_status_two[CHGST_POS_OPT +: 2] = current_optimizer_state;
    end

    always_comb begin
        thermistor_status = CHGST_ZERO;
        thermistor_status[2:0] = zone_code;
    end

    always_comb begin
        fault_status = CHGST_ZERO;
        fault_status[CHGST_POS_OVP] = input_overvoltage;
        fault_status[CHGST_POS_SHUT] = thermal_shutdown;
        fault_status[CHGST_POS_TMR] = safety_timer_expired;
    end

    ////////////////////////////////////////////////////////////////////
    // address decode; unmapped offsets read zero
    assign hit_one = (rd_addr == CHGST_ADDR_STATUS_ONE);
    assign hit_two = (rd_addr == CHGST_ADDR_STATUS_TWO);
    assign hit_ts = (rd_addr == CHGST_ADDR_THERMISTOR);
    assign hit_fault = (rd_addr == CHGST_ADDR_FAULT);
    assign next_rd_data = hit_one ? charge_status_one :
                          hit_two ? charge_status_two :
                          hit_ts ? thermistor_status :
                          hit_fault ? fault_status : CHGST_ZERO;

    // read capture; a read changes no state besides the data latch and the valid flag
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= CHGST_ZERO;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= next_rd_data;
            end
        end
    end
endmodule

// ---- chgst_status_regs_properties.sv ----
/*
 * chgst_status_regs_properties: checker on the status bank ports.
 * assumes: bound to chgst_status_regs; one clock, sync active-low reset.
 */
`timescale 1ns/100ps
module chgst_status_regs_properties
    import chgst_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // status inputs
    input wire logic input_current_regulation,
    input wire logic current_limit_pin,
    input wire logic input_voltage_regulation,
    input wire logic die_thermal_loop_active,
    input wire logic host_timer_expired,
    input wire chgst_pkg::chgst_phase_t charge_phase,
    input wire logic supply_good,
    // read port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // which register a taken read selects
    wire rd_one = rd_en && rd_addr == CHGST_ADDR_STATUS_ONE;
    wire rd_two = rd_en && rd_addr == CHGST_ADDR_STATUS_TWO;
    wire rd_zone = rd_en && rd_addr == CHGST_ADDR_THERMISTOR;
    wire icur = input_current_regulation || current_limit_pin;
    ////////////////////////////////////////////////////////////////
    a_current_bit: assert property (rd_one |=> rd_data[6] == $past(icur))
        else $error("current loop bit wrong");
    a_voltage_bit: assert property (rd_one |=> rd_data[5] == $past(input_voltage_regulation))
        else $error("voltage loop bit wrong");
    a_thermal_bit: assert property (rd_one |=> rd_data[4] == $past(die_thermal_loop_active))
        else $error("thermal bit wrong");
    a_timer_bit: assert property (rd_one |=> rd_data[3] == $past(host_timer_expired))
        else $error("watchdog bit wrong");
    a_phase_field: assert property (rd_one && charge_phase != 3'h7 |=> rd_data[2:0] == $past(charge_phase))
        else $error("phase field wrong");
    a_phase_never: assert property (rd_one |=> rd_data[2:0] != 3'h7)
        else $error("reserved phase code read");
    a_one_reserved: assert property (rd_one |=> !rd_data[7])
        else $error("status one top bit set");
    a_two_fixed: assert property (rd_two |=> !rd_data[3] && !rd_data[0] && rd_data[7] == $past(supply_good))
        else $error("status two fixed bits wrong");
    a_opt_legal: assert property (rd_two |=> rd_data[2:1] != 2'h3)
        else $error("reserved optimizer code read");
    a_zone_reserved: assert property (rd_zone |=> rd_data[7:3] == 5'h00)
        else $error("zone reserved bits set");
    a_data_holds: assert property (!rd_en |=> $stable(rd_data) && !rd_valid)
        else $error("data moved without read");
    a_valid_follows: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    // main scenarios
    cover property (rd_one ##1 rd_valid);
    cover property (rd_two && supply_good);
    cover property (rd_zone ##1 rd_valid);
endmodule

// ---- chgst_status_regs_test.sv ----
/*
 * chgst_status_regs_test: table-driven bench for the status bank.
 * assumes: inputs driven at falling edge; read answers one cycle later.
 */
`timescale 1ns/100ps
module chgst_status_regs_test;
    import chgst_pkg::*;
    logic clock, rst_n, wd, rd_en, rd_valid;
    logic [19:0] v;
    logic [7:0] rd_addr, rd_data;
    int err_count, compares;
    // status inputs, then expected 0b, 0c, 0d, 0e
    logic [51:0] rows [8] = '{
        {20'h0_0000, 8'h00, 8'h00, 8'h00, 8'h00}, {20'h8_1994, 8'h41, 8'h92, 8'h02, 8'h80},
        {20'h4_22da, 8'h42, 8'h24, 8'h03, 8'h40}, {20'h2_3329, 8'h23, 8'h30, 8'h05, 8'h10},
        {20'h1_4d30, 8'h14, 8'hd0, 8'h06, 8'h00}, {20'h0_d608, 8'h0d, 8'h60, 8'h00, 8'h00},
        {20'hc_6038, 8'h46, 8'h00, 8'h00, 8'h00}, {20'h0_7f70, 8'h00, 8'hd0, 8'h06, 8'h00}};
    chgst_status_regs i_chgst_status_regs (.clock(clock), .rst_n(rst_n),
        .input_current_regulation(v[19]), .current_limit_pin(v[18]), .input_voltage_regulation(v[17]),
        .die_thermal_loop_active(v[16]), .host_timer_expired(v[15]), .charge_phase(chgst_phase_t'(v[14:12])),
        .supply_good(v[11]), .source_detected(chgst_source_t'(v[10:8])), .weak_source_detect(wd),
        .input_current_optimizer(v[7]), .optimizer_found(v[6]), .thermistor_zone(v[5:3]),
        .input_overvoltage(v[2]), .thermal_shutdown(v[1]), .safety_timer_expired(v[0]),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
    ////////////////////////////////////////////////////////////////
    // compare valid flag and data together
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one read cycle, answer looked at in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clock);
        rd_en = 1'b0;
        check({rd_valid, rd_data}, {1'b1, e});
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (3000) @(posedge clock);
        err_count++;
        give_verdict();
    end
    // main sequence
    initial begin
        {rst_n, wd, rd_en, rd_addr, v, err_count, compares} = '0;
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        check({rd_valid, rd_data}, 9'h000);
        foreach (rows[i]) begin
            @(negedge clock);
            v = rows[i][51:32];
            rd(CHGST_ADDR_STATUS_ONE, rows[i][31:24]);
            rd(CHGST_ADDR_STATUS_TWO, rows[i][23:16]);
            rd(CHGST_ADDR_THERMISTOR, rows[i][15:8]);
            rd(CHGST_ADDR_FAULT, rows[i][7:0]);
        end
        // weak source run: six pulses not enough, seventh flags it
        v = 20'h0_0800;
        for (int i = 0; i < 7; i++) begin
            if (i == 6)
                rd(CHGST_ADDR_STATUS_TWO, 8'h80);
            @(negedge clock);
            wd = 1'b1;
            @(negedge clock);
            wd = 1'b0;
        end
        rd(CHGST_ADDR_STATUS_TWO, 8'hc0);
        rd(CHGST_ADDR_STATUS_TWO, 8'hc0);
        // valid drops after one cycle while data holds
        @(negedge clock);
        check({rd_valid, rd_data}, 9'h0c0);
        // mid-run reset clears the read latch and the weak run
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        check({rd_valid, rd_data}, 9'h000);
        rd(CHGST_ADDR_STATUS_TWO, 8'h80);
        v = 20'h0_0900;
        rd(CHGST_ADDR_STATUS_TWO, 8'h90);
        rd(8'h0f, 8'h00);
        give_verdict();
    end
endmodule
bind chgst_status_regs chgst_status_regs_properties i_chgst_status_regs_properties (.clock(clock), .rst_n(rst_n),
    .input_current_regulation(input_current_regulation), .current_limit_pin(current_limit_pin),
    .input_voltage_regulation(input_voltage_regulation), .die_thermal_loop_active(die_thermal_loop_active),
    .host_timer_expired(host_timer_expired), .charge_phase(charge_phase), .supply_good(supply_good),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
